/* File: src/pcm_pkg.sv */
// Constants and carrier types for the configuration header tail and power capability registers
package pcm_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  // Host side (configuration cycle) byte offsets
  localparam logic [8:0] PCM_PCI_CAP_HEAD  = 9'h034;
  localparam logic [8:0] PCM_PCI_IRQ_LINE  = 9'h03C;
  localparam logic [8:0] PCM_PCI_IRQ_PIN   = 9'h03D;
  localparam logic [8:0] PCM_PCI_MIN_GNT   = 9'h03E;
  localparam logic [8:0] PCM_PCI_MAX_LAT   = 9'h03F;
  localparam logic [8:0] PCM_PCI_PM_ID     = 9'h040;
  localparam logic [8:0] PCM_PCI_PM_NEXT   = 9'h041;
  localparam logic [8:0] PCM_PCI_PM_CAPS   = 9'h042;
  // Local side byte offsets
  localparam logic [8:0] PCM_LOC_CAP_HEAD  = 9'h034;
  localparam logic [8:0] PCM_LOC_IRQ_LINE  = 9'h03C;
  localparam logic [8:0] PCM_LOC_PM_ID     = 9'h180;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0]  PCM_RST_CAP_HEAD = 8'h40;
  localparam logic [7:0]  PCM_RST_IRQ_LINE = 8'h00;
  localparam logic [7:0]  PCM_RST_IRQ_PIN  = 8'h01;
  localparam logic [7:0]  PCM_RST_MIN_GNT  = 8'h00;
  localparam logic [7:0]  PCM_RST_MAX_LAT  = 8'h00;
  localparam logic [7:0]  PCM_PM_CAP_ID    = 8'h01;
  localparam logic [7:0]  PCM_RST_PM_NEXT  = 8'h48;
  localparam logic [15:0] PCM_RST_PM_CAPS  = 16'h0002;

  // ****************************************
  // Capabilities word fields
  // ****************************************
  localparam int PCM_CAPS_VER_LSB   = 0;
  localparam int PCM_CAPS_CLK_BIT   = 3;
  localparam int PCM_CAPS_RSVD_BIT  = 4;
  localparam int PCM_CAPS_INIT_BIT  = 5;
  localparam int PCM_CAPS_AUX_LSB   = 6;
  localparam int PCM_CAPS_D1_BIT    = 9;
  localparam int PCM_CAPS_D2_BIT    = 10;
  localparam int PCM_CAPS_WAKE_LSB  = 11;

  // Per-bit write permission of each source
  localparam logic [7:0]  PCM_MASK_BYTE_ALL = 8'hFF;
  localparam logic [7:0]  PCM_MASK_BYTE_NONE = 8'h00;
  localparam logic [15:0] PCM_CAPS_LOC_MASK = 16'hFFEF;
  localparam logic [15:0] PCM_CAPS_EE_MASK  = 16'hFE07;
  localparam logic [15:0] PCM_CAPS_NONE     = 16'h0000;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic [4:0] wake_state_mask;
    logic       deep_sleep_supported;
    logic       light_sleep_supported;
    logic [2:0] aux_current;
    logic       init_after_d0;
    logic       rsvd;
    logic       wake_needs_clk;
    logic [2:0] version;
  } pcm_caps_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [8:0]  addr;
    logic [3:0]  be;
    logic [31:0] data;
  } pcm_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } pcm_rsp_t;

endpackage

/* File: src/pcm_field_reg.sv */
// One configuration field with separate local, loader and host write permissions
`timescale 1ns/100ps
module pcm_field_reg
  import pcm_pkg::*;
#(
  parameter int           W        = 8,
  parameter logic [W-1:0] RST      = '0,
  parameter logic [W-1:0] LOC_MASK = '0,
  parameter logic [W-1:0] EE_MASK  = '0,
  parameter logic [W-1:0] PCI_MASK = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Bit write enables and data per source
  input  wire logic [W-1:0] pci_we,
  input  wire logic [W-1:0] pci_d,
  input  wire logic [W-1:0] ee_we,
  input  wire logic [W-1:0] ee_d,
  input  wire logic [W-1:0] loc_we,
  input  wire logic [W-1:0] loc_d,
  // Stored value
  output logic      [W-1:0] q
);

  logic [W-1:0] q_d;
  logic [W-1:0] m_pci;
  logic [W-1:0] m_ee;
  logic [W-1:0] m_loc;

  // Local wins over loader, loader over host
  always_comb begin
    m_pci = pci_we & PCI_MASK;
    m_ee  = ee_we & EE_MASK;
    m_loc = loc_we & LOC_MASK;
    q_d   = q;
    q_d   = (q_d & ~m_pci) | (pci_d & m_pci);
    q_d   = (q_d & ~m_ee) | (ee_d & m_ee);
    q_d   = (q_d & ~m_loc) | (loc_d & m_loc);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= RST;
    end else begin
      q <= q_d;
    end
  end

endmodule

/* File: src/pcm_port_resp.sv */
// Registered acknowledge and read data for one access port
`timescale 1ns/100ps
module pcm_port_resp
  import pcm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Request and selected word
  input  wire logic        req_wr,
  input  wire logic        req_rd,
  input  wire logic [31:0] word,
  // Answer
  output pcm_rsp_t         rsp_q
);

  pcm_rsp_t rsp_d;

  // Read data holds until the next read
  always_comb begin
    rsp_d.ack   = req_wr | req_rd;
    rsp_d.rdata = req_rd ? word : rsp_q.rdata;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rsp_q <= '0;
    end else begin
      rsp_q <= rsp_d;
    end
  end

endmodule

/* File: src/pcm_cfg_regs.sv */
// Configuration header tail and power management capability registers
//
// Function
// (R1) The capability list head resets to 40h, only the local side may write it, and bits 31:8 read zero.
// (R2) The interrupt line byte resets to zero and is written by the host and by the loader.
// (R3) The interrupt pin byte resets to 1 and only the local side or the loader may write it.
// (R4) The minimum grant byte resets to zero, is read-only to the host, and loadable locally or by the loader.
// (R5) The maximum latency byte resets to zero, is read-only to the host, and loadable locally or by the loader.
// (R6) The power capability ID always reads 01h and ignores every write.
// (R7) The power next pointer resets to 48h and only the local side may write it.
// (R8) The version field resets to 010b and is written only locally or by the loader.
// (R9) The wake-needs-clock bit resets to 0 and only the local side may write it.
// (R10) The init-after-D0 bit resets to 0 and only the local side may write it.
// (R11) The light and deep sleep support bits reset to 0 and are written locally or by the loader.
// (R12) The wake state mask resets to zero and is written locally or by the loader.
// (R13) The aux current field resets to 000b and is local-only; reserved bit 4 reads 0 and ignores writes.
// (R14) Host writes to protected fields are acknowledged but change nothing, while local writes take effect.
`timescale 1ns/100ps
module pcm_cfg_regs
  import pcm_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Host configuration cycles
  input  wire pcm_req_t pci_req,
  output pcm_rsp_t      pci_rsp,
  // Local processor accesses
  input  wire pcm_req_t loc_req,
  output pcm_rsp_t      loc_rsp,
  // Serial loader writes
  input  wire pcm_req_t ee_req,
  // Field values for the rest of the bridge
  output logic [7:0]    irq_line_route,
  output pcm_caps_t     power_capabilities
);

  // ****************************************
  // Decode
  // ****************************************
  function automatic logic [31:0] be_bits(input logic hit, input logic [3:0] be);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{hit & be[i]}};
    end
    return m;
  endfunction

  logic        pci_head_hit;
  logic        pci_irq_hit;
  logic        pci_pm_hit;
  logic        loc_head_hit;
  logic        loc_irq_hit;
  logic        loc_pm_hit;
  logic        ee_irq_hit;
  logic        ee_pm_hit;
  logic [31:0] pci_head_wm;
  logic [31:0] pci_irq_wm;
  logic [31:0] pci_pm_wm;
  logic [31:0] loc_head_wm;
  logic [31:0] loc_irq_wm;
  logic [31:0] loc_pm_wm;
  logic [31:0] ee_irq_wm;
  logic [31:0] ee_pm_wm;

  // Loader uses host offsets; it never reaches the list head
  always_comb begin
    pci_head_hit = pci_req.addr[8:2] == PCM_PCI_CAP_HEAD[8:2];
    pci_irq_hit  = pci_req.addr[8:2] == PCM_PCI_IRQ_LINE[8:2];
    pci_pm_hit   = pci_req.addr[8:2] == PCM_PCI_PM_ID[8:2];
    loc_head_hit = loc_req.addr[8:2] == PCM_LOC_CAP_HEAD[8:2];
    loc_irq_hit  = loc_req.addr[8:2] == PCM_LOC_IRQ_LINE[8:2];
    loc_pm_hit   = loc_req.addr[8:2] == PCM_LOC_PM_ID[8:2];
    ee_irq_hit   = ee_req.addr[8:2] == PCM_PCI_IRQ_LINE[8:2];
    ee_pm_hit    = ee_req.addr[8:2] == PCM_PCI_PM_ID[8:2];
    pci_head_wm  = be_bits(pci_req.wr & pci_head_hit, pci_req.be);
    pci_irq_wm   = be_bits(pci_req.wr & pci_irq_hit, pci_req.be);
    pci_pm_wm    = be_bits(pci_req.wr & pci_pm_hit, pci_req.be);
    loc_head_wm  = be_bits(loc_req.wr & loc_head_hit, loc_req.be);
    loc_irq_wm   = be_bits(loc_req.wr & loc_irq_hit, loc_req.be);
    loc_pm_wm    = be_bits(loc_req.wr & loc_pm_hit, loc_req.be);
    ee_irq_wm    = be_bits(ee_req.wr & ee_irq_hit, ee_req.be);
    ee_pm_wm     = be_bits(ee_req.wr & ee_pm_hit, ee_req.be);
  end

  // ****************************************
  // Fields
  // ****************************************
  logic [7:0]  cap_head_q;
  logic [7:0]  irq_pin_q;
  logic [7:0]  min_gnt_q;
  logic [7:0]  max_lat_q;
  logic [7:0]  next_cap_q;
  logic [15:0] caps_q;

  pcm_field_reg #(.W(8), .RST(PCM_RST_CAP_HEAD), .LOC_MASK(PCM_MASK_BYTE_ALL),  // R1 R14
    .EE_MASK(PCM_MASK_BYTE_NONE), .PCI_MASK(PCM_MASK_BYTE_NONE)) u_cap_head (
    .clk(clk), .rst(rst),
    .pci_we(pci_head_wm[7:0]), .pci_d(pci_req.data[7:0]),
    .ee_we(8'h00), .ee_d(8'h00),
    .loc_we(loc_head_wm[7:0]), .loc_d(loc_req.data[7:0]),
    .q(cap_head_q)
  );

  pcm_field_reg #(.W(8), .RST(PCM_RST_IRQ_LINE), .LOC_MASK(PCM_MASK_BYTE_ALL),  // R2
    .EE_MASK(PCM_MASK_BYTE_ALL), .PCI_MASK(PCM_MASK_BYTE_ALL)) u_irq_line (
    .clk(clk), .rst(rst),
    .pci_we(pci_irq_wm[7:0]), .pci_d(pci_req.data[7:0]),
    .ee_we(ee_irq_wm[7:0]), .ee_d(ee_req.data[7:0]),
    .loc_we(loc_irq_wm[7:0]), .loc_d(loc_req.data[7:0]),
    .q(irq_line_route)
  );

  pcm_field_reg #(.W(8), .RST(PCM_RST_IRQ_PIN), .LOC_MASK(PCM_MASK_BYTE_ALL),  // R3 R14
    .EE_MASK(PCM_MASK_BYTE_ALL), .PCI_MASK(PCM_MASK_BYTE_NONE)) u_irq_pin (
    .clk(clk), .rst(rst),
    .pci_we(pci_irq_wm[15:8]), .pci_d(pci_req.data[15:8]),
    .ee_we(ee_irq_wm[15:8]), .ee_d(ee_req.data[15:8]),
    .loc_we(loc_irq_wm[15:8]), .loc_d(loc_req.data[15:8]),
    .q(irq_pin_q)
  );

  pcm_field_reg #(.W(8), .RST(PCM_RST_MIN_GNT), .LOC_MASK(PCM_MASK_BYTE_ALL),  // R4 R14
    .EE_MASK(PCM_MASK_BYTE_ALL), .PCI_MASK(PCM_MASK_BYTE_NONE)) u_min_gnt (
    .clk(clk), .rst(rst),
    .pci_we(pci_irq_wm[23:16]), .pci_d(pci_req.data[23:16]),
    .ee_we(ee_irq_wm[23:16]), .ee_d(ee_req.data[23:16]),
    .loc_we(loc_irq_wm[23:16]), .loc_d(loc_req.data[23:16]),
    .q(min_gnt_q)
  );

  pcm_field_reg #(.W(8), .RST(PCM_RST_MAX_LAT), .LOC_MASK(PCM_MASK_BYTE_ALL),  // R5 R14
    .EE_MASK(PCM_MASK_BYTE_ALL), .PCI_MASK(PCM_MASK_BYTE_NONE)) u_max_lat (
    .clk(clk), .rst(rst),
    .pci_we(pci_irq_wm[31:24]), .pci_d(pci_req.data[31:24]),
    .ee_we(ee_irq_wm[31:24]), .ee_d(ee_req.data[31:24]),
    .loc_we(loc_irq_wm[31:24]), .loc_d(loc_req.data[31:24]),
    .q(max_lat_q)
  );

  pcm_field_reg #(.W(8), .RST(PCM_RST_PM_NEXT), .LOC_MASK(PCM_MASK_BYTE_ALL),  // R7 R14
    .EE_MASK(PCM_MASK_BYTE_NONE), .PCI_MASK(PCM_MASK_BYTE_NONE)) u_next_cap (
    .clk(clk), .rst(rst),
    .pci_we(pci_pm_wm[15:8]), .pci_d(pci_req.data[15:8]),
    .ee_we(ee_pm_wm[15:8]), .ee_d(ee_req.data[15:8]),
    .loc_we(loc_pm_wm[15:8]), .loc_d(loc_req.data[15:8]),
    .q(next_cap_q)
  );

  // Bit 4 has no write permission anywhere, so it stays at its reset zero
  pcm_field_reg #(.W(16), .RST(PCM_RST_PM_CAPS), .LOC_MASK(PCM_CAPS_LOC_MASK),  // R8 R9 R10 R11 R12 R13
    .EE_MASK(PCM_CAPS_EE_MASK), .PCI_MASK(PCM_CAPS_NONE)) u_caps (
    .clk(clk), .rst(rst),
    .pci_we(pci_pm_wm[31:16]), .pci_d(pci_req.data[31:16]),
    .ee_we(ee_pm_wm[31:16]), .ee_d(ee_req.data[31:16]),
    .loc_we(loc_pm_wm[31:16]), .loc_d(loc_req.data[31:16]),
    .q(caps_q)
  );

  assign power_capabilities = pcm_caps_t'(caps_q);

  // ****************************************
  // Read words and answers
  // ****************************************
  logic [31:0] head_word;
  logic [31:0] irq_word;
  logic [31:0] pm_word;
  logic [31:0] pci_word;
  logic [31:0] loc_word;

  // Unmapped words read zero
  always_comb begin
    head_word = {24'h00_0000, cap_head_q};  // R1
    irq_word  = {max_lat_q, min_gnt_q, irq_pin_q, irq_line_route};
    pm_word   = {caps_q, next_cap_q, PCM_PM_CAP_ID};  // R6
    pci_word  = pci_head_hit ? head_word : pci_irq_hit ? irq_word : pci_pm_hit ? pm_word : 32'h0000_0000;
    loc_word  = loc_head_hit ? head_word : loc_irq_hit ? irq_word : loc_pm_hit ? pm_word : 32'h0000_0000;
  end

  pcm_port_resp u_pci_resp (
    .clk(clk), .rst(rst),
    .req_wr(pci_req.wr), .req_rd(pci_req.rd), .word(pci_word),
    .rsp_q(pci_rsp)
  );

  pcm_port_resp u_loc_resp (
    .clk(clk), .rst(rst),
    .req_wr(loc_req.wr), .req_rd(loc_req.rd), .word(loc_word),
    .rsp_q(loc_rsp)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic only_pci_irq;
  logic only_pci_pm;
  assign only_pci_irq = pci_req.wr & pci_irq_hit & ~(loc_req.wr & loc_irq_hit) & ~(ee_req.wr & ee_irq_hit);
  assign only_pci_pm  = pci_req.wr & pci_pm_hit & ~(loc_req.wr & loc_pm_hit) & ~(ee_req.wr & ee_pm_hit);

  property p_head_host_ro;
    pci_req.wr && pci_head_hit && !(loc_req.wr && loc_head_hit) |=> $stable(cap_head_q);
  endproperty
  a_head_host_ro: assert property (p_head_host_ro) else $error("host changed list head");  // R1

  property p_head_upper_zero;
    pci_req.rd && pci_head_hit |=> pci_rsp.ack && pci_rsp.rdata[31:8] == 24'h00_0000
      && pci_rsp.rdata[7:0] == $past(cap_head_q);
  endproperty
  a_head_upper_zero: assert property (p_head_upper_zero) else $error("list head read wrong");  // R1

  property p_line_host_wr;
    only_pci_irq && pci_req.be[0] |=> irq_line_route == $past(pci_req.data[7:0]);
  endproperty
  a_line_host_wr: assert property (p_line_host_wr) else $error("line byte not written");  // R2

  property p_pin_gnt_lat_host_ro;
    only_pci_irq |=> $stable(irq_pin_q) && $stable(min_gnt_q) && $stable(max_lat_q);
  endproperty
  a_pin_gnt_lat_host_ro: assert property (p_pin_gnt_lat_host_ro) else $error("host wrote protected byte");  // R3 R4 R5

  property p_id_const;
    pci_req.rd && pci_pm_hit ##1 pci_rsp.ack |-> pci_rsp.rdata[7:0] == PCM_PM_CAP_ID;
  endproperty
  a_id_const: assert property (p_id_const) else $error("cap id not 01h");  // R6

  property p_pm_host_ro;
    only_pci_pm |=> $stable(next_cap_q) && $stable(caps_q);
  endproperty
  a_pm_host_ro: assert property (p_pm_host_ro) else $error("host wrote power fields");  // R7 R8 R14

  property p_caps_loc_wr;
    loc_req.wr && loc_pm_hit && loc_req.be[2] |=> caps_q[7:0] == ($past(loc_req.data[23:16]) & 8'hEF);
  endproperty
  a_caps_loc_wr: assert property (p_caps_loc_wr) else $error("local caps write lost");  // R9 R10 R13

  property p_ee_caps_mask;
    ee_req.wr && ee_pm_hit && ee_req.be[3] && !(loc_req.wr && loc_pm_hit)
      |=> caps_q[15:9] == $past(ee_req.data[31:25]) && caps_q[8:3] == $past(caps_q[8:3]);
  endproperty
  a_ee_caps_mask: assert property (p_ee_caps_mask) else $error("loader caps mask wrong");  // R11 R12

  property p_rsvd_zero;
    caps_q[PCM_CAPS_RSVD_BIT] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved caps bit set");  // R13

  property p_ack_one_cycle;
    (pci_req.wr || pci_req.rd) |=> pci_rsp.ack ##1 (pci_rsp.ack == $past(pci_req.wr || pci_req.rd));
  endproperty
  a_ack_one_cycle: assert property (p_ack_one_cycle) else $error("host ack timing wrong");  // R14

  // Local reads and local and loader writes, where the priority order decides the winner
  property p_head_loc_wr;
    loc_req.wr && loc_head_hit && loc_req.be[0] |=> cap_head_q == $past(loc_req.data[7:0]);
  endproperty
  a_head_loc_wr: assert property (p_head_loc_wr) else $error("local list head write lost");  // R1 R14

  property p_line_ee_wr;
    ee_req.wr && ee_irq_hit && ee_req.be[0] && !(loc_req.wr && loc_irq_hit && loc_req.be[0])
      |=> irq_line_route == $past(ee_req.data[7:0]);
  endproperty
  a_line_ee_wr: assert property (p_line_ee_wr) else $error("loader line write lost");  // R2

  property p_pin_ee_wr;
    ee_req.wr && ee_irq_hit && ee_req.be[1] && !(loc_req.wr && loc_irq_hit)
      |=> irq_pin_q == $past(ee_req.data[15:8]);
  endproperty
  a_pin_ee_wr: assert property (p_pin_ee_wr) else $error("loader pin write lost");  // R3

  property p_gnt_lat_ee_wr;
    ee_req.wr && ee_irq_hit && ee_req.be[3:2] == 2'b11 && !(loc_req.wr && loc_irq_hit)
      |=> {max_lat_q, min_gnt_q} == $past(ee_req.data[31:16]);
  endproperty
  a_gnt_lat_ee_wr: assert property (p_gnt_lat_ee_wr) else $error("loader grant or latency write lost");  // R4 R5

  property p_next_loc_wr;
    loc_req.wr && loc_pm_hit && loc_req.be[1] |=> next_cap_q == $past(loc_req.data[15:8]);
  endproperty
  a_next_loc_wr: assert property (p_next_loc_wr) else $error("local next write lost");  // R7 R14

  property p_ee_local_only;
    ee_req.wr && ee_pm_hit && !(loc_req.wr && loc_pm_hit)
      |=> $stable(next_cap_q) && $stable(caps_q[8:3]);
  endproperty
  a_ee_local_only: assert property (p_ee_local_only) else $error("loader wrote local-only field");  // R7 R9 R10 R13

  property p_caps_loc_hi;
    loc_req.wr && loc_pm_hit && loc_req.be[3] |=> caps_q[15:8] == $past(loc_req.data[31:24]);
  endproperty
  a_caps_loc_hi: assert property (p_caps_loc_hi) else $error("local sleep or wake bits lost");  // R11 R12

  property p_loc_id_read;
    loc_req.rd && loc_pm_hit |=> loc_rsp.ack && loc_rsp.rdata[7:0] == PCM_PM_CAP_ID;
  endproperty
  a_loc_id_read: assert property (p_loc_id_read) else $error("local cap id read wrong");  // R6

  c_host_head_wr: cover property (pci_req.wr && pci_head_hit ##1 pci_rsp.ack);
  c_loc_next_wr: cover property (loc_req.wr && loc_pm_hit && loc_req.be[1] ##1 next_cap_q == 8'h00);
  c_ee_irq_load: cover property (ee_req.wr && ee_irq_hit && ee_req.be[0]);
  c_loc_id_read: cover property (loc_req.rd && loc_pm_hit ##1 loc_rsp.ack);

endmodule

/* File: sim/pcm_host_model.sv */
// Behavioural host bridge that issues configuration cycles
`timescale 1ns/100ps
module pcm_host_model
  import pcm_pkg::*;
(
  // Clock
  input  wire logic     clk,
  // Configuration cycle port
  output pcm_req_t      pci_req,
  input  wire pcm_rsp_t pci_rsp
);
  initial pci_req = '0;

  // ****************************************
  // One configuration cycle
  // ****************************************
  // Drives at the falling edge and samples the answer at the next falling edge
  task automatic cyc(input logic wr, input logic [8:0] addr, input logic [3:0] be,
                     input logic [31:0] data, output logic [31:0] rdata, output logic ok);
    @(negedge clk);
    pci_req = '{wr: wr, rd: !wr, addr: addr, be: be, data: data};
    @(negedge clk);
    ok      = pci_rsp.ack;
    rdata   = pci_rsp.rdata;
    // Released lines are scrambled so stale values never look valid
    pci_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, be: ~be, data: ~data};
  endtask
endmodule

/* File: sim/tb_top.sv */
// Self-checking testbench for the configuration tail and power capability registers
`timescale 1ns/100ps
module tb_top
  import pcm_pkg::*;
;
  logic      clk;
  logic      rst;
  pcm_req_t  pci_req;
  pcm_rsp_t  pci_rsp;
  pcm_req_t  loc_req;
  pcm_rsp_t  loc_rsp;
  pcm_req_t  ee_req;
  logic [7:0] irq_line_route;
  pcm_caps_t power_capabilities;
  int        n_mismatch;
  int        compares;

  always #20 clk = ~clk;

  pcm_cfg_regs uut (
    .clk                (clk),
    .rst                (rst),
    .pci_req            (pci_req),
    .pci_rsp            (pci_rsp),
    .loc_req            (loc_req),
    .loc_rsp            (loc_rsp),
    .ee_req             (ee_req),
    .irq_line_route     (irq_line_route),
    .power_capabilities (power_capabilities)
  );

  pcm_host_model host (
    .clk     (clk),
    .pci_req (pci_req),
    .pci_rsp (pci_rsp)
  );

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hrd(input logic [8:0] addr, input logic [31:0] exp);
    logic [31:0] rd;
    logic        ok;
    host.cyc(1'b0, addr, 4'hF, 32'h0000_0000, rd, ok);
    chk({31'h0000_0000, ok}, 32'h0000_0001);
    chk(rd, exp);
  endtask

  task automatic hwr(input logic [8:0] addr, input logic [3:0] be, input logic [31:0] data);
    logic [31:0] rd;
    logic        ok;
    host.cyc(1'b1, addr, be, data, rd, ok);
    chk({31'h0000_0000, ok}, 32'h0000_0001);
  endtask

  // Local access; read data judged only on reads
  task automatic lcyc(input logic wr, input logic [8:0] addr, input logic [3:0] be,
                      input logic [31:0] data, input logic [31:0] exp);
    @(negedge clk);
    loc_req = '{wr: wr, rd: !wr, addr: addr, be: be, data: data};
    @(negedge clk);
    chk({31'h0000_0000, loc_rsp.ack}, 32'h0000_0001);
    if (!wr) chk(loc_rsp.rdata, exp);
    loc_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, be: ~be, data: ~data};
  endtask

  // Loader write has no answer; effect shows the cycle after
  task automatic ewr(input logic [8:0] addr, input logic [3:0] be, input logic [31:0] data);
    @(negedge clk);
    ee_req = '{wr: 1'b1, rd: 1'b0, addr: addr, be: be, data: data};
    @(negedge clk);
    ee_req = '{wr: 1'b0, rd: 1'b0, addr: ~addr, be: ~be, data: ~data};
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    hrd(PCM_PCI_CAP_HEAD, 32'h0000_0040);
    hrd(PCM_PCI_IRQ_LINE, 32'h0000_0100);
    hrd(PCM_PCI_PM_ID, 32'h0002_4801);
    lcyc(1'b0, PCM_LOC_PM_ID, 4'hF, 32'h0000_0000, 32'h0002_4801);
    chk({16'h0000, power_capabilities}, 32'h0000_0002);
    chk({24'h00_0000, irq_line_route}, 32'h0000_0000);
  endtask

  // Host writes everywhere: only the line byte may move
  task automatic t_host_wr;
    hwr(PCM_PCI_CAP_HEAD, 4'hF, 32'hFFFF_FFFF);
    hrd(PCM_PCI_CAP_HEAD, 32'h0000_0040);
    hwr(PCM_PCI_IRQ_LINE, 4'hF, 32'hFFFF_FFA5);
    hrd(PCM_PCI_IRQ_LINE, 32'h0000_01A5);
    chk({24'h00_0000, irq_line_route}, 32'h0000_00A5);
    hwr(PCM_PCI_PM_ID, 4'hF, 32'hFFFF_FFFF);
    hrd(PCM_PCI_PM_ID, 32'h0002_4801);
    hwr(9'h100, 4'hF, 32'hFFFF_FFFF);
    hrd(9'h100, 32'h0000_0000);
  endtask

  task automatic t_local_wr;
    lcyc(1'b1, PCM_LOC_CAP_HEAD, 4'hF, 32'h3C3C_3C55, 32'h0000_0000);
    hrd(PCM_PCI_CAP_HEAD, 32'h0000_0055);
    lcyc(1'b1, PCM_LOC_IRQ_LINE, 4'hF, 32'h3344_5566, 32'h0000_0000);
    hrd(PCM_PCI_IRQ_LINE, 32'h3344_5566);
    lcyc(1'b1, PCM_LOC_PM_ID, 4'hF, 32'hFFFF_FFFF, 32'h0000_0000);
    hrd(PCM_PCI_PM_ID, 32'hFFEF_FF01);
    chk({16'h0000, power_capabilities}, 32'h0000_FFEF);
    // Clearing next marks power management as the last capability
    lcyc(1'b1, PCM_LOC_PM_ID, 4'hE, 32'h0000_0000, 32'h0000_0000);
    lcyc(1'b0, PCM_LOC_PM_ID, 4'hF, 32'h0000_0000, 32'h0000_0001);
  endtask

  // Loader may touch only its own bits
  task automatic t_loader;
    ewr(PCM_PCI_PM_ID, 4'hF, 32'hFFFF_FFFF);
    hrd(PCM_PCI_PM_ID, 32'hFE07_0001);
    ewr(PCM_PCI_IRQ_LINE, 4'h1, 32'hAABB_CCDD);
    hrd(PCM_PCI_IRQ_LINE, 32'h3344_55DD);
    chk({24'h00_0000, irq_line_route}, 32'h0000_00DD);
    ewr(PCM_PCI_IRQ_LINE, 4'hE, 32'hAABB_CCDD);
    hrd(PCM_PCI_IRQ_LINE, 32'hAABB_CCDD);
    ewr(PCM_PCI_CAP_HEAD, 4'hF, 32'h0000_0000);
    hrd(PCM_PCI_CAP_HEAD, 32'h0000_0055);
  endtask

  // Reset in mid-run must bring back every value the scenarios above changed
  task automatic t_mid_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    chk({24'h00_0000, irq_line_route}, 32'h0000_0000);
    chk({16'h0000, power_capabilities}, 32'h0000_0002);
    rst = 1'b0;
    t_reset();
  endtask

  // ****************************************
  // Run control
  // ****************************************
  task automatic stop_test;
    $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    #50_000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    clk        = 1'b0;
    rst        = 1'b1;
    ee_req     = '0;
    loc_req    = '0;
    n_mismatch = 0;
    compares   = 0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_host_wr();
    t_local_wr();
    t_loader();
    t_mid_reset();
    stop_test();
  end
endmodule
